// >>> common/npmc_cfg_if.sv
// Interface carrying latched words, conditions and decoded controls between the loader and the decoder.
`timescale 1ns/10ps
interface npmc_cfg_if;
  logic [15:0]             init_word;
  logic [15:0]             mng_word;
  logic                    variant_ext;
  logic                    clkreq_present;
  logic                    d0a;
  logic                    wake_en;
  logic                    auto_rd;
  logic                    spd_en;
  logic                    wdma_dis;
  logic                    d0a_dis;
  logic                    mng_gate;
  npmc_pkg::npmc_mng_mode_t mng_mode;
  logic                    clk_rm_ok;
  modport src (output init_word, mng_word, variant_ext, clkreq_present, d0a, wake_en, auto_rd,
               input spd_en, wdma_dis, d0a_dis, mng_gate, mng_mode, clk_rm_ok);
  modport dec (input init_word, mng_word, variant_ext, clkreq_present, d0a, wake_en, auto_rd,
               output spd_en, wdma_dis, d0a_dis, mng_gate, mng_mode, clk_rm_ok);
endinterface

// >>> common/npmc_map.svh
// Register offsets, field positions and reset values of the power and manageability configuration loader.
// Summary of operation
// RL1: Clock removal capability reports 1b from bit 2 of the initialization word.
// RL2: While capability reads 0b, the platform keeps reference clocks running in L1, L2/3.
// RL3: Each function reports its own clock removal capability, from its own word only.
// RL4: Software permits clock removal only if every function reports 1b.
// RL5: Clock removal capability counts only where the clock request pin exists.
// RL6: Bit 1 set enables PHY smart power-down; clear leaves it disabled. The code enables it only in the base variant.
// RL7: Wake DMA gating disable stops gating in D0a with wake, manageability, or auto-read.
// RL8: D0a DMA gating disable at bit 0 keeps the DMA clock ungated in D0a.
// RL9: Mode field bits 3:2 select off (clock gated), ASF, pass-through, or advanced mode.
// RL10: Hardware ignores bits 7 and 6 of the manageability word; image keeps them zero.
// RL11: In the base variant the image sets reserved bit 0 of the initialization word.
// RL12: Advanced mode images also enable all manageability functions in word 49h.
// RL13: Both words are latched during auto-read and held until the next auto-read.
`ifndef NPMC_MAP_SVH
`define NPMC_MAP_SVH
`define NPMC_IDX_CTRL      8'h00
`define NPMC_IDX_STAT      8'h01
`define NPMC_IDX_INIT      8'h0F
`define NPMC_IDX_MNG       8'h10
`define NPMC_CTRL_RELOAD   0
`define NPMC_STAT_LOADED   0
`define NPMC_STAT_BUSY     1
`define NPMC_STAT_CLKRM    2
`define NPMC_STAT_VARIANT  3
`define NPMC_B_CLKPM       2
`define NPMC_B_SPD         1
`define NPMC_B_WDMA        1
`define NPMC_B_D0A         0
`define NPMC_F_MNG_HI      3
`define NPMC_F_MNG_LO      2
`define NPMC_INIT_RST      16'h0002
`define NPMC_MNG_RST       16'h0000
`endif

// >>> common/npmc_pkg.sv
// Types and shared decode functions of the configuration loader.
`include "npmc_map.svh"
package npmc_pkg;
  typedef enum logic [3:0] {
    NPMC_ST_IDLE    = 4'b0001,
    NPMC_ST_RD_INIT = 4'b0010,
    NPMC_ST_RD_MNG  = 4'b0100,
    NPMC_ST_DONE    = 4'b1000
  } npmc_ld_state_t;

  typedef enum logic [1:0] {
    NPMC_MNG_OFF  = 2'h0,
    NPMC_MNG_ASF  = 2'h1,
    NPMC_MNG_PASS = 2'h2,
    NPMC_MNG_ADV  = 2'h3
  } npmc_mng_mode_t;

  // Extracts the mode field; bits 7 and 6 are never looked at.
  function automatic npmc_mng_mode_t npmc_mode_of(input logic [15:0] w);
    return npmc_mng_mode_t'(w[`NPMC_F_MNG_HI:`NPMC_F_MNG_LO]);
  endfunction
endpackage

// >>> test/npmc_nvm_model.sv
// Behavioural model of the nonvolatile configuration memory that answers the loader's word reads.
`timescale 1ns/10ps
module npmc_nvm_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        nvm_rd_req,
  input  wire logic [7:0]  nvm_rd_addr,
  input  wire logic [15:0] img_init,
  input  wire logic [15:0] img_mng,
  input  wire logic [3:0]  lat,
  output logic             nvm_rd_ack,
  output logic      [15:0] nvm_rd_data
);
  logic [3:0] wait_q;

  // Waits the access latency, then acks one word; between acks the data lines toggle so nothing stale looks valid.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q      <= 4'h0;
      nvm_rd_ack  <= 1'b0;
      nvm_rd_data <= 16'hA5A5;
    end else if (nvm_rd_req && !nvm_rd_ack && wait_q >= lat) begin
      wait_q      <= 4'h0;
      nvm_rd_ack  <= 1'b1;
      nvm_rd_data <= (nvm_rd_addr == 8'h0F) ? img_init : img_mng;
    end else begin
      wait_q      <= nvm_rd_req ? wait_q + 4'h1 : 4'h0;
      nvm_rd_ack  <= 1'b0;
      nvm_rd_data <= ~nvm_rd_data;
    end
  end
endmodule // npmc_nvm_model

// >>> test/npmc_top_tb.sv
// Self-checking testbench of the configuration loader: register accesses, auto-reads and decoded controls.
`timescale 1ns/10ps
module npmc_top_tb;
  import npmc_pkg::*;
  typedef struct packed {
    logic        v, ck, d0, wk;
    logic [15:0] iw, mw;
  } npmc_case_t;

  logic                pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]         paddr;
  logic [31:0]         pwdata, prdata, rdat, out_v;
  logic                nvm_rd_req, nvm_rd_ack, d0a_active, wake_enabled, clkreq_strap, variant_strap;
  logic [7:0]          nvm_rd_addr;
  logic [15:0]         nvm_rd_data, img_init, img_mng, prev;
  logic                cfg_loaded, clk_removal_ok, phy_spd_en, wake_dma_gate_dis, dma_gate_dis, mng_clk_gate, rerr;
  npmc_mng_mode_t      manageability_mode_select;
  npmc_case_t          tab [6];
  npmc_case_t          c;
  int                  n_errors, check_count, cycles;

  npmc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .nvm_rd_req(nvm_rd_req), .nvm_rd_addr(nvm_rd_addr), .nvm_rd_ack(nvm_rd_ack), .nvm_rd_data(nvm_rd_data),
    .d0a_active(d0a_active), .wake_enabled(wake_enabled), .clkreq_strap(clkreq_strap),
    .variant_strap(variant_strap), .cfg_loaded(cfg_loaded), .clk_removal_ok(clk_removal_ok),
    .phy_spd_en(phy_spd_en), .wake_dma_gate_dis(wake_dma_gate_dis), .dma_gate_dis(dma_gate_dis),
    .mng_clk_gate(mng_clk_gate), .manageability_mode_select(manageability_mode_select));

  npmc_nvm_model nvm_u (.pclk(pclk), .presetn(presetn), .nvm_rd_req(nvm_rd_req), .nvm_rd_addr(nvm_rd_addr),
    .img_init(img_init), .img_mng(img_mng), .lat(4'h6), .nvm_rd_ack(nvm_rd_ack), .nvm_rd_data(nvm_rd_data));

  // Gathers the decoded controls into one word so a single compare covers them.
  assign out_v = {25'h0, clk_removal_ok, phy_spd_en, wake_dma_gate_dis, dma_gate_dis, mng_clk_gate,
                  manageability_mode_select};

  // Works out the expected controls of one settled case.
  function automatic logic [31:0] exp_out(input npmc_case_t e);
    logic [1:0] m;
    m = e.mw[3:2];
    return {25'h0, e.iw[2] & e.ck, e.iw[1] & !e.v, e.v & e.iw[1] & e.d0 & (e.wk | (m != 2'h0)),
            e.v & e.iw[0] & e.d0, m == 2'h0, m};
  endfunction

  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; entered just after a rising edge, ends one idle edge after completion.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50) chk(32'h0, 32'h1, "no pready");
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Reads a register and compares its data.
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0, rdat, rerr);
    chk(rdat, exp, what);
  endtask

  // Waits a bounded time for the memory request to reach a level.
  task automatic wait_req(input logic lvl);
    int n;
    n = 0;
    while (nvm_rd_req !== lvl && n < 100) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 100) chk(32'h0, 32'h1, "memory request stuck");
  endtask

  // Prints the verdict and ends the run.
  task automatic tally_and_finish();
    if (n_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Clock at 25 MHz.
  always #20 pclk = ~pclk;

  // Cuts a hang short.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // Main sequence; images keep bits 7:6 clear except case 1, which checks that they are ignored.
  initial begin
    tab[0] = {4'b0100, 16'h0007, 16'h0000};
    tab[1] = {4'b0011, 16'h0005, 16'h00C4};
    tab[2] = {4'b1110, 16'h0007, 16'h0008};
    tab[3] = {4'b1111, 16'h0006, 16'h000C};
    tab[4] = {4'b1010, 16'h0003, 16'h0000};
    tab[5] = {4'b1101, 16'h0003, 16'h0004};
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {d0a_active, wake_enabled, clkreq_strap, variant_strap} = 4'b0100;
    img_init = tab[0].iw;
    img_mng = tab[0].mw;
    prev = tab[0].iw;
    repeat (10) @(posedge pclk);
    chk(out_v, 32'h14, "reset controls");
    chk({31'h0, cfg_loaded}, 32'h0, "loaded in reset");
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    wait_req(1'b1);
    chk({24'h0, nvm_rd_addr}, 32'h0F, "first word address");
    wait_req(1'b0);
    repeat (2) @(posedge pclk);
    chk({31'h0, cfg_loaded}, 32'h1, "loaded after auto-read");
    for (int i = 0; i < 6; i++) begin
      variant_strap <= tab[i].v;
      clkreq_strap  <= tab[i].ck;
      d0a_active    <= tab[i].d0;
      wake_enabled  <= tab[i].wk;
      img_init      <= tab[i].iw;
      img_mng       <= tab[i].mw;
      repeat (4) @(posedge pclk);
      apb(1'b1, 12'h000, 32'h1, rdat, rerr);
      wait_req(1'b1);
      repeat (2) @(posedge pclk);
      chk({31'h0, wake_dma_gate_dis}, {31'h0, tab[i].v & prev[1]}, "gating during auto-read");
      wait_req(1'b0);
      repeat (3) @(posedge pclk);
      chk(out_v, exp_out(tab[i]), "decoded controls");
      rd(12'h03C, {16'h0, tab[i].iw}, "init word");
      rd(12'h040, {16'h0, tab[i].mw}, "manageability word");
      rd(12'h004, {28'h0, tab[i].v, tab[i].iw[2] & tab[i].ck, 2'b01}, "status");
      prev = tab[i].iw;
    end
    c = tab[5];
    c.d0 = 1'b1;
    img_init <= 16'hFFFF;
    img_mng <= 16'hFFFF;
    d0a_active <= 1'b1;
    repeat (20) @(posedge pclk);
    chk(out_v, exp_out(c), "controls held without reload");
    apb(1'b1, 12'h03C, 32'hFFFF, rdat, rerr);
    rd(12'h03C, {16'h0, tab[5].iw}, "read-only word");
    apb(1'b0, 12'h080, 32'h0, rdat, rerr);
    chk({rdat[30:0], rerr}, 32'h1, "unmapped access");
    tally_and_finish();
  end
endmodule // npmc_top_tb

// >>> verilog/npmc_clk_gate_ctrl.sv
// Decoder that turns the latched words into registered power, clock and manageability controls.
`timescale 1ns/10ps
module npmc_clk_gate_ctrl (
  input  wire logic pclk,
  input  wire logic presetn,
  npmc_cfg_if.dec   cfg
);
  import npmc_pkg::*;

  npmc_mng_mode_t mode;

  assign mode = npmc_mode_of(cfg.mng_word); // [RL10]

  // Capability and smart power-down come from the initialization word, gated by the clock request pin and by the base variant.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg.clk_rm_ok <= 1'b0;
      cfg.spd_en    <= 1'b0;
    end else begin
      cfg.clk_rm_ok <= cfg.init_word[`NPMC_B_CLKPM] & cfg.clkreq_present; // [RL1] [RL3] [RL5]
      cfg.spd_en    <= ~cfg.variant_ext & cfg.init_word[`NPMC_B_SPD];    // [RL6]
    end
  end

  // Gating disables apply in the extended variant, where bits 1 and 0 carry them, and wdma_dis also while in reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg.wdma_dis <= 1'b1;
      cfg.d0a_dis  <= 1'b0;
    end else begin
      cfg.wdma_dis <= cfg.variant_ext & cfg.init_word[`NPMC_B_WDMA] &
                      (cfg.auto_rd | (cfg.d0a & (cfg.wake_en | (mode != NPMC_MNG_OFF)))); // [RL7]
      cfg.d0a_dis  <= cfg.variant_ext & cfg.init_word[`NPMC_B_D0A] & cfg.d0a;            // [RL8]
    end
  end

  // Manageability mode and its clock gate.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg.mng_mode <= NPMC_MNG_OFF;
      cfg.mng_gate <= 1'b1;
    end else begin
      cfg.mng_mode <= mode;                   // [RL9]
      cfg.mng_gate <= (mode == NPMC_MNG_OFF); // [RL9]
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_CLKRM_CAP: assert property (cfg.clk_rm_ok == ($past(cfg.init_word[`NPMC_B_CLKPM]) &&
      $past(cfg.clkreq_present))) else $error("clock removal capability wrong"); // [RL1]
  AST_CLKRM_NO_PIN: assert property (!cfg.clkreq_present |=> !cfg.clk_rm_ok)
      else $error("capability shown without clock request pin"); // [RL5]
  AST_OWN_WORD: assert property (cfg.clk_rm_ok |-> $past(cfg.init_word[`NPMC_B_CLKPM]))
      else $error("capability not taken from own word"); // [RL3]
  AST_SPD: assert property ($past(presetn) |->
      cfg.spd_en == ($past(cfg.init_word[`NPMC_B_SPD]) && !$past(cfg.variant_ext)))
      else $error("smart power-down enable wrong"); // [RL6]
  AST_WDMA: assert property ((cfg.variant_ext && cfg.init_word[`NPMC_B_WDMA] && cfg.auto_rd) |=> cfg.wdma_dis)
      else $error("wake DMA gating not disabled in auto-read"); // [RL7]
  AST_D0A: assert property ((cfg.d0a_dis) |-> $past(cfg.d0a) && $past(cfg.init_word[`NPMC_B_D0A]))
      else $error("D0a DMA gating disable without cause"); // [RL8]
  AST_MNG_GATE: assert property (cfg.mng_gate == (cfg.mng_mode == NPMC_MNG_OFF))
      else $error("manageability clock gate disagrees with mode"); // [RL9]
  AST_FW_IGNORE: assert property (cfg.mng_mode == $past(cfg.mng_word[`NPMC_F_MNG_HI:`NPMC_F_MNG_LO]))
      else $error("mode not taken from bits 3:2"); // [RL10]
endmodule // npmc_clk_gate_ctrl

// >>> verilog/npmc_sync2.sv
// Two-flop synchroniser for the two strap pins.
`timescale 1ns/10ps
module npmc_sync2 (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] din,
  output logic      [1:0] dout
);
  logic [1:0] meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 2'h0;
      dout   <= 2'h0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule // npmc_sync2

// >>> verilog/npmc_top.sv
// Top of the configuration loader: APB slave, auto-read sequencer and latched configuration words.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
module npmc_top (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic                          pready,
  output logic      [31:0]              prdata,
  output logic                          pslverr,
  output logic                          nvm_rd_req,
  output logic      [7:0]               nvm_rd_addr,
  input  wire logic                     nvm_rd_ack,
  input  wire logic [15:0]              nvm_rd_data,
  input  wire logic                     d0a_active,
  input  wire logic                     wake_enabled,
  input  wire logic                     clkreq_strap,
  input  wire logic                     variant_strap,
  output logic                          cfg_loaded,
  output logic                          clk_removal_ok,
  output logic                          phy_spd_en,
  output logic                          wake_dma_gate_dis,
  output logic                          dma_gate_dis,
  output logic                          mng_clk_gate,
  output npmc_pkg::npmc_mng_mode_t      manageability_mode_select
);
  import npmc_pkg::*;

  npmc_ld_state_t state_q;
  npmc_ld_state_t state_d;
  logic [15:0]    init_power_clock_control_q;
  logic [15:0]    manageability_config_word_q;
  logic           start_q;
  logic           loaded_q;
  logic [1:0]     strap_sync;
  logic           setup_ph;
  logic           wr_reload;
  logic [31:0]    rd_mux;
  logic           rd_hit;

  npmc_cfg_if cfg ();

  // Word address to byte address match on the APB bus.
  function automatic logic reg_hit(input logic [11:0] a, input logic [7:0] idx);
    return a == {2'b00, idx, 2'b00};
  endfunction

  // Strap pins come from outside the clock domain.
  npmc_sync2 u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({variant_strap, clkreq_strap}),
    .dout    (strap_sync)
  );

  assign cfg.init_word      = init_power_clock_control_q;
  assign cfg.mng_word       = manageability_config_word_q;
  assign cfg.clkreq_present = strap_sync[0];
  assign cfg.variant_ext    = strap_sync[1];
  assign cfg.d0a            = d0a_active;
  assign cfg.wake_en        = wake_enabled;
  assign cfg.auto_rd        = (state_q == NPMC_ST_RD_INIT) || (state_q == NPMC_ST_RD_MNG);

  npmc_clk_gate_ctrl u_dec (
    .pclk    (pclk),
    .presetn (presetn),
    .cfg     (cfg.dec)
  );

  // Decoded controls leave the block straight from the decoder's flops.
  assign clk_removal_ok            = cfg.clk_rm_ok;
  assign phy_spd_en                = cfg.spd_en;
  assign wake_dma_gate_dis         = cfg.wdma_dis;
  assign dma_gate_dis              = cfg.d0a_dis;
  assign mng_clk_gate              = cfg.mng_gate;
  assign manageability_mode_select = cfg.mng_mode;
  assign cfg_loaded                = loaded_q;

  assign setup_ph  = psel & ~penable;
  assign wr_reload = psel & penable & pready & pwrite & reg_hit(paddr, `NPMC_IDX_CTRL) &
                     pwdata[`NPMC_CTRL_RELOAD];

  // Read data selection; unmapped addresses are flagged as errors.
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    if (reg_hit(paddr, `NPMC_IDX_CTRL)) begin
      rd_mux[`NPMC_CTRL_RELOAD] = start_q;
    end else if (reg_hit(paddr, `NPMC_IDX_STAT)) begin
      rd_mux[`NPMC_STAT_LOADED]  = loaded_q;
      rd_mux[`NPMC_STAT_BUSY]    = cfg.auto_rd;
      rd_mux[`NPMC_STAT_CLKRM]   = cfg.clk_rm_ok;
      rd_mux[`NPMC_STAT_VARIANT] = cfg.variant_ext;
    end else if (reg_hit(paddr, `NPMC_IDX_INIT)) begin
      rd_mux[15:0] = init_power_clock_control_q;
    end else if (reg_hit(paddr, `NPMC_IDX_MNG)) begin
      rd_mux[15:0] = manageability_config_word_q;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Zero-wait APB answer: ready, data and error are prepared in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_ph;
      prdata  <= (setup_ph & ~pwrite) ? rd_mux : 32'h0000_0000;
      pslverr <= setup_ph & ~rd_hit;
    end
  end

  // Pending auto-read: armed by reset, re-armed by software; a new request wins over the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q <= 1'b1;
    end else begin
      start_q <= wr_reload | (start_q & (state_q != NPMC_ST_IDLE)); // [RL13]
    end
  end

  // Sequencer next state.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      NPMC_ST_IDLE: begin
        if (start_q) begin
          state_d = NPMC_ST_RD_INIT;
        end
      end
      NPMC_ST_RD_INIT: begin
        if (nvm_rd_ack) begin
          state_d = NPMC_ST_RD_MNG;
        end
      end
      NPMC_ST_RD_MNG: begin
        if (nvm_rd_ack) begin
          state_d = NPMC_ST_DONE;
        end
      end
      NPMC_ST_DONE: begin
        state_d = NPMC_ST_IDLE;
      end
      default: begin
        state_d = NPMC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= NPMC_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Read request towards the memory, held with its address until acknowledged.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nvm_rd_req  <= 1'b0;
      nvm_rd_addr <= 8'h00;
    end else if (state_q == NPMC_ST_IDLE && start_q) begin
      nvm_rd_req  <= 1'b1;
      nvm_rd_addr <= `NPMC_IDX_INIT;
    end else if (state_q == NPMC_ST_RD_INIT && nvm_rd_ack) begin
      nvm_rd_addr <= `NPMC_IDX_MNG;
    end else if (state_q == NPMC_ST_RD_MNG && nvm_rd_ack) begin
      nvm_rd_req  <= 1'b0;
    end
  end

  // Words are captured only on their acknowledge and otherwise held.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_power_clock_control_q  <= `NPMC_INIT_RST;
      manageability_config_word_q <= `NPMC_MNG_RST;
    end else begin
      if (state_q == NPMC_ST_RD_INIT && nvm_rd_ack) begin
        init_power_clock_control_q <= nvm_rd_data;  // [RL13]
      end
      if (state_q == NPMC_ST_RD_MNG && nvm_rd_ack) begin
        manageability_config_word_q <= nvm_rd_data; // [RL13]
      end
    end
  end

  // Loaded flag rises once both words are in and stays until reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loaded_q <= 1'b0;
    end else if (state_q == NPMC_ST_RD_MNG && nvm_rd_ack) begin
      loaded_q <= 1'b1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_INIT_LATCH: assert property ((state_q == NPMC_ST_RD_INIT && nvm_rd_ack) |=>
      init_power_clock_control_q == $past(nvm_rd_data)) else $error("init word not latched"); // [RL13]
  AST_WORD_HOLD: assert property (!(cfg.auto_rd && nvm_rd_ack) |=>
      $stable(init_power_clock_control_q) && $stable(manageability_config_word_q))
      else $error("configuration word changed outside auto-read"); // [RL13]
  AST_REQ_HELD: assert property ((nvm_rd_req && !nvm_rd_ack) |=> nvm_rd_req && $stable(nvm_rd_addr))
      else $error("memory request dropped before acknowledge"); // [RL13]
  AST_RELOAD_START: assert property (wr_reload |=> ##[0:2] cfg.auto_rd)
      else $error("reload did not start auto-read"); // [RL13]

  COV_RELOAD: cover property (wr_reload ##1 start_q);
  COV_FULL_LOAD: cover property (state_q == NPMC_ST_RD_MNG && nvm_rd_ack ##1 loaded_q);
  COV_ADV_MODE: cover property (manageability_mode_select == NPMC_MNG_ADV && !mng_clk_gate);
endmodule // npmc_top
